// ===== core/smd_map.svh
// Constants for the set-mode command decoder
`ifndef SMD_MAP_SVH
`define SMD_MAP_SVH
`define SMD_CMD_CODE 8'h56
`define SMD_MODE_LIMIT 16'h0000
`define SMD_MODE_GROUP 16'h0001
`define SMD_MODE_DCMOT 16'h0002
`define SMD_MODE_AFB 16'h0003
`define SMD_MODE_AFILT 16'h0004
`define SMD_MODE_DVFILT 16'h0005
`define SMD_MODE_XOVER 16'h0006
`define SMD_MODE_PWREAD 16'h0007
`define SMD_MODE_HIRATE 16'h0009
`define SMD_MODE_NZSPEED 16'h000F
`define SMD_MODE_EMULT 16'h0012
`define SMD_MODE_SPI_A 16'h0014
`define SMD_MODE_SPI_B 16'h0015
`define SMD_MODE_SPI_DLY 16'h0016
`define SMD_MODE_FFILT 16'h0018
`define SMD_MODE_SINE 16'h0019
`define SMD_MODE_HALL 16'h001A
`define SMD_MODE_SHORT 16'h001B
`define SMD_MODE_I2C_SET 16'h001C
`define SMD_MODE_I2C_TX 16'h001D
`define SMD_MODE_I2C_RX 16'h001E
`define SMD_SPI_MAX_CODE 16'h0006
`define SMD_CYCLE_NS 120000
`define SMD_CLK_NS 10
`define SMD_CYCLE_CLKS (`SMD_CYCLE_NS / `SMD_CLK_NS)
`define SMD_FF_UNITY 16'h8000
`define SMD_EMULT_RESET 16'h0001
`define SMD_FF_LOOP_RESET 1'b1
`endif

// ===== core/smd_pkg.sv
// Types for the set-mode command decoder
package smd_pkg;
	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic [15:0] mode;
		logic [15:0] data;
	} smd_cmd_s;
	typedef enum logic [1:0] {SMD_IDLE, SMD_BUSY, SMD_ACK} smd_state_e;
	typedef struct packed {
		smd_state_e state;
		logic ack;
		logic reject;
		logic limit_switch_select;
		logic group_response_enable;
		logic dc_motor_select;
		logic [1:0] analog_feedback_select;
		logic [15:0] analog_input_filter;
		logic [15:0] drive_voltage_filter;
		logic [15:0] velocity_crossover;
		logic [15:0] pulse_width_read;
		logic hirate_enable;
		logic nonzero_endspeed_enable;
		logic [15:0] encoder_multiplier;
		logic [2:0] spi_rate_a;
		logic [2:0] spi_rate_b;
		logic [15:0] spi_delay_ticks;
		logic [15:0] ff_coeff;
		logic ff_use_loop_filter;
		logic [15:0] sine_base;
		logic sine_enable;
		logic hall_input_read;
		logic short_request;
		logic short_armed;
		logic short_active;
		logic [15:0] i2c_addr;
		logic i2c_setup;
		logic i2c_tx;
		logic i2c_rx;
		logic [15:0] i2c_reg;
		logic [16:0] tick;
		logic cycle_pulse;
		logic cs_keepalive;
		logic [31:0] sine_phase;
		logic [2:0] hall_value;
	} smd_state_s;
endpackage

// ===== core/smd_decoder.sv
// Set-mode command decoder with mode registers and cycle-rate helpers
`timescale 1ns/10ps
`include "smd_map.svh"
// What this block does
// - One command code 86, mode word selects
// - Mode 0 disables or enables limit switches
// - Mode 1 answers group address too
// - Mode 2 selects stepper or DC drive
// - Mode 3 picks analog position feedback source
// - Mode 6 sets velocity crossover frequency
// - Pulse-width read with power-of-two prescale
// - Mode 9 stores the high-rate pulse measurement enable
// - Nonzero start and stop speeds from registers
// - Encoder multiplier, zero or one means unity
// - Modes 20,21 set second SPI rate
// - Delayed SPI read, chip select keepalive pulse
// - Feedforward coefficient, zero uses loop filter
// - Sinewave phase advances by frequency each cycle
// - Sinewave adds only during trajectory motion
// - Hall inputs 2,3,4 give commutation value
// - Disable shorts windings if armed while enabled
// - Mode 28 strobes I2C setup with the unit address
// - Mode 29 strobes I2C transmit with its register
// - Mode 30 strobes I2C receive with its buffer register
module smd_decoder import smd_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire smd_cmd_s cmd,
	input wire logic motor_enabled,
	input wire logic hw_drive_disable,
	input wire logic motion_active,
	input wire logic [31:0] sine_freq,
	input wire logic [4:0] gen_inputs,
	output logic ack,
	output logic reject,
	output logic limit_switch_select,
	output logic group_response_enable,
	output logic dc_motor_select,
	output logic [1:0] analog_feedback_select,
	output logic [15:0] analog_input_filter,
	output logic [15:0] drive_voltage_filter,
	output logic [15:0] velocity_crossover,
	output logic [15:0] pulse_width_read,
	output logic hirate_enable,
	output logic nonzero_endspeed_enable,
	output logic [15:0] encoder_multiplier,
	output logic [2:0] spi_rate_a,
	output logic [2:0] spi_rate_b,
	output logic [15:0] spi_delay_ticks,
	output logic [15:0] ff_coeff,
	output logic ff_use_loop_filter,
	output logic [15:0] sine_base,
	output logic sine_enable,
	output logic hall_input_read,
	output logic [2:0] hall_value,
	output logic short_active,
	output logic [15:0] i2c_addr,
	output logic i2c_setup,
	output logic i2c_tx,
	output logic i2c_rx,
	output logic [15:0] i2c_reg,
	output logic cycle_pulse,
	output logic cs_keepalive,
	output logic [31:0] sine_phase
);
	// One control cycle is 120us of system clocks
	// Tick width covers the count at 100 MHz with room to spare
	localparam logic [16:0] CYCLE_LAST = 17'(`SMD_CYCLE_CLKS - 1);

	// Power-up state: everything off except unity multiplier and loop filter
	localparam smd_state_s ST_RESET = '{
		state: SMD_IDLE,
		ack: 1'b0,
		reject: 1'b0,
		limit_switch_select: 1'b0,
		group_response_enable: 1'b0,
		dc_motor_select: 1'b0,
		analog_feedback_select: 2'h0,
		analog_input_filter: 16'h0000,
		drive_voltage_filter: 16'h0000,
		velocity_crossover: 16'h0000,
		pulse_width_read: 16'h0000,
		hirate_enable: 1'b0,
		nonzero_endspeed_enable: 1'b0,
		encoder_multiplier: `SMD_EMULT_RESET,
		spi_rate_a: 3'h0,
		spi_rate_b: 3'h0,
		spi_delay_ticks: 16'h0000,
		ff_coeff: 16'h0000,
		ff_use_loop_filter: `SMD_FF_LOOP_RESET,
		sine_base: 16'h0000,
		sine_enable: 1'b0,
		hall_input_read: 1'b0,
		short_request: 1'b0,
		short_armed: 1'b0,
		short_active: 1'b0,
		i2c_addr: 16'h0000,
		i2c_setup: 1'b0,
		i2c_tx: 1'b0,
		i2c_rx: 1'b0,
		i2c_reg: 16'h0000,
		tick: 17'h00000,
		cycle_pulse: 1'b0,
		cs_keepalive: 1'b0,
		sine_phase: 32'h00000000,
		hall_value: 3'h0
	};

	// Registered state and its next value
	smd_state_s st;
	smd_state_s next_st;
	// Command accepted this cycle
	logic take;

	// Next-state logic for decoding and cycle helpers
	always_comb begin
		next_st = st;
		next_st.ack = 1'b0;
		next_st.reject = 1'b0;
		next_st.i2c_setup = 1'b0;
		next_st.i2c_tx = 1'b0;
		next_st.i2c_rx = 1'b0;
		next_st.cycle_pulse = 1'b0;
		next_st.cs_keepalive = 1'b0;
		// Only the shared code is decoded; every other code passes by untouched
		take = cmd.valid && (cmd.code == `SMD_CMD_CODE);

		// 120us control cycle tick
		// Keepalive and phase advance both ride on the cycle wrap
		if (st.tick == CYCLE_LAST) begin
			next_st.tick = '0;
			next_st.cycle_pulse = 1'b1;
			if (st.spi_delay_ticks != 16'h0000) begin
				next_st.cs_keepalive = 1'b1;
			end
			if (st.sine_enable && motion_active) begin
				next_st.sine_phase = st.sine_phase + sine_freq;
			end
		end else begin
			next_st.tick = st.tick + 17'h00001;
		end

		// Hall sensors U,V,W on general inputs 2,3,4
		if (st.hall_input_read) begin
			next_st.hall_value = gen_inputs[4:2];
		end

		// Winding short: armed once the motor is enabled while the request is set
		// Hardware disable always wins, since the drivers are off then
		if (hw_drive_disable || !st.short_request) begin
			next_st.short_active = 1'b0;
		end else begin
			next_st.short_active = st.short_armed && !motor_enabled;
		end

		// A later enable arms a request that was made while disabled
		if (st.short_request && motor_enabled) begin
			next_st.short_armed = 1'b1;
		end

		// Command handshake
		// Busy and ack states keep the host three cycles apart
		case (st.state)
			SMD_IDLE: begin
				if (take) begin
					next_st.state = SMD_BUSY;
					case (cmd.mode)
						// Limit switches off or set from stored config
						`SMD_MODE_LIMIT: begin
							next_st.limit_switch_select = cmd.data[0];
						end
						// Answer the group address as well
						`SMD_MODE_GROUP: begin
							next_st.group_response_enable = cmd.data[0];
						end
						// Stepper or DC drive type
						`SMD_MODE_DCMOT: begin
							next_st.dc_motor_select = cmd.data[0];
						end
						// Analog feedback source, only 0, 1 and 3 accepted
						`SMD_MODE_AFB: begin
							if (cmd.data == 16'h0000 || cmd.data == 16'h0001 || cmd.data == 16'h0003) begin
								next_st.analog_feedback_select = cmd.data[1:0];
							end else begin
								next_st.reject = 1'b1;
							end
						end
						// Analog input filter setting
						`SMD_MODE_AFILT: begin
							next_st.analog_input_filter = cmd.data;
						end
						// Drive voltage filter setting
						`SMD_MODE_DVFILT: begin
							next_st.drive_voltage_filter = cmd.data;
						end
						// Velocity crossover frequency
						`SMD_MODE_XOVER: begin
							next_st.velocity_crossover = cmd.data;
						end
						// Pulse-width read prescale exponent
						`SMD_MODE_PWREAD: begin
							next_st.pulse_width_read = cmd.data;
						end
						// High-rate pulse measurement on or off
						`SMD_MODE_HIRATE: begin
							next_st.hirate_enable = cmd.data[0];
						end
						// Nonzero start and stop speeds
						`SMD_MODE_NZSPEED: begin
							next_st.nonzero_endspeed_enable = cmd.data[0];
						end
						// Encoder multiplier, zero stored as unity
						`SMD_MODE_EMULT: begin
							next_st.encoder_multiplier = (cmd.data == 16'h0000) ? 16'h0001 : cmd.data;
						end
						// Second SPI port rates; codes above six refused
						// Each port keeps its own rate code
						`SMD_MODE_SPI_A, `SMD_MODE_SPI_B: begin
							if (cmd.data > `SMD_SPI_MAX_CODE) begin
								next_st.reject = 1'b1;
							end else if (cmd.mode == `SMD_MODE_SPI_A) begin
								next_st.spi_rate_a = cmd.data[2:0];
							end else begin
								next_st.spi_rate_b = cmd.data[2:0];
							end
						end
						// Delayed read tick count; nonzero enables keepalive
						`SMD_MODE_SPI_DLY: begin
							next_st.spi_delay_ticks = cmd.data;
						end
						// Feedforward coefficient; zero selects the loop filter
						`SMD_MODE_FFILT: begin
							next_st.ff_coeff = cmd.data;
							next_st.ff_use_loop_filter = (cmd.data == 16'h0000);
						end
						// Sinewave base register; zero turns it off
						// Phase restarts at zero to avoid a jump
						`SMD_MODE_SINE: begin
							next_st.sine_base = cmd.data;
							next_st.sine_enable = (cmd.data != 16'h0000);
							next_st.sine_phase = '0;
						end
						// Hall sensor read on or off
						`SMD_MODE_HALL: begin
							next_st.hall_input_read = (cmd.data != 16'h0000);
						end
						// Winding short request
						// Armed at once only if the motor is enabled now
						`SMD_MODE_SHORT: begin
							next_st.short_request = cmd.data[0];
							next_st.short_armed = cmd.data[0] && motor_enabled;
						end
						// I2C setup with the unit address
						`SMD_MODE_I2C_SET: begin
							next_st.i2c_addr = cmd.data;
							next_st.i2c_setup = 1'b1;
						end
						// I2C transmit strobe with its register
						`SMD_MODE_I2C_TX: begin
							next_st.i2c_reg = cmd.data;
							next_st.i2c_tx = 1'b1;
						end
						// I2C receive strobe with its buffer register
						`SMD_MODE_I2C_RX: begin
							next_st.i2c_reg = cmd.data;
							next_st.i2c_rx = 1'b1;
						end
						// Reserved and unknown modes are refused but still answered
						default: next_st.reject = 1'b1;
					endcase
				end
			end
			// One cycle for the mode write to settle
			SMD_BUSY: begin
				next_st.state = SMD_ACK;
				next_st.ack = 1'b1;
			end
			// Ack is out; back to idle on the next edge
			SMD_ACK: next_st.state = SMD_IDLE;
			default: next_st.state = SMD_IDLE;
		endcase
	end

	// State register
	// Reset values are constants only
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from state
	assign ack = st.ack;
	assign reject = st.reject;

	// Drive and feedback selections
	assign limit_switch_select = st.limit_switch_select;
	assign group_response_enable = st.group_response_enable;
	assign dc_motor_select = st.dc_motor_select;
	assign analog_feedback_select = st.analog_feedback_select;

	// Filter and measurement settings
	assign analog_input_filter = st.analog_input_filter;
	assign drive_voltage_filter = st.drive_voltage_filter;
	assign velocity_crossover = st.velocity_crossover;
	assign pulse_width_read = st.pulse_width_read;

	// Pulse and motion options
	assign hirate_enable = st.hirate_enable;
	assign nonzero_endspeed_enable = st.nonzero_endspeed_enable;
	assign encoder_multiplier = st.encoder_multiplier;

	// Second SPI port
	assign spi_rate_a = st.spi_rate_a;
	assign spi_rate_b = st.spi_rate_b;
	assign spi_delay_ticks = st.spi_delay_ticks;

	// Feedforward filter
	assign ff_coeff = st.ff_coeff;
	assign ff_use_loop_filter = st.ff_use_loop_filter;

	// Sinewave setup
	assign sine_base = st.sine_base;
	assign sine_enable = st.sine_enable;

	// Hall sensing and winding short
	assign hall_input_read = st.hall_input_read;
	assign hall_value = st.hall_value;
	assign short_active = st.short_active;

	// I2C strobes and their operands
	assign i2c_addr = st.i2c_addr;
	assign i2c_setup = st.i2c_setup;
	assign i2c_tx = st.i2c_tx;
	assign i2c_rx = st.i2c_rx;
	assign i2c_reg = st.i2c_reg;

	// Control cycle helpers
	assign cycle_pulse = st.cycle_pulse;
	assign cs_keepalive = st.cs_keepalive;
	assign sine_phase = st.sine_phase;
endmodule // smd_decoder

// ===== verif/smd_chk.sv
// Assertion checker for the set-mode decoder
`timescale 1ns/10ps
`include "smd_map.svh"
module smd_chk import smd_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire smd_cmd_s cmd,
	input wire logic hw_drive_disable,
	input wire logic ack,
	input wire logic reject,
	input wire logic group_response_enable,
	input wire logic [15:0] encoder_multiplier,
	input wire logic [15:0] spi_delay_ticks,
	input wire logic short_active,
	input wire logic i2c_setup,
	input wire logic cycle_pulse,
	input wire logic cs_keepalive
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic [13:0] gap;
	logic seen;
	// Cycles since the last control-cycle pulse
	always_ff @(posedge clk_sys) begin
		if (reset || cycle_pulse) begin
			gap <= 14'h0;
		end else begin
			gap <= gap + 14'h1;
		end
		seen <= !reset && (seen || cycle_pulse);
	end
	sequence take_s;
		cmd.valid && cmd.code == `SMD_CMD_CODE;
	endsequence
	sequence answer_s;
		!ack ##1 ack;
	endsequence
	ack_delay_a: assert property (take_s |=> answer_s) else $error("ack late");
	ack_pulse_a: assert property (ack |=> !ack) else $error("ack too long");
	reject_ack_a: assert property (reject |=> ack) else $error("reject without ack");
	group_cause_a: assert property ($changed(group_response_enable) |->
		$past(cmd.valid) && $past(cmd.mode) == `SMD_MODE_GROUP) else $error("group changed");
	keepalive_a: assert property (cs_keepalive |-> cycle_pulse && spi_delay_ticks != 16'h0)
		else $error("keepalive off cycle");
	period_a: assert property (cycle_pulse && seen |-> gap == 14'(`SMD_CYCLE_CLKS - 1))
		else $error("cycle period");
	short_hw_a: assert property (hw_drive_disable && $past(hw_drive_disable) |-> !short_active)
		else $error("short under hw disable");
	emult_unity_a: assert property (encoder_multiplier != 16'h0) else $error("multiplier zero");
	i2c_setup_a: assert property (i2c_setup |-> $past(cmd.valid) && $past(cmd.mode) == `SMD_MODE_I2C_SET)
		else $error("i2c setup stray");
endmodule // smd_chk
bind smd_decoder smd_chk u_chk (.clk_sys, .reset, .cmd, .hw_drive_disable, .ack, .reject,
	.group_response_enable, .encoder_multiplier, .spi_delay_ticks, .short_active, .i2c_setup,
	.cycle_pulse, .cs_keepalive);

// ===== verif/smd_host.sv
// Host model that issues set-mode commands
`timescale 1ns/10ps
`include "smd_map.svh"
module smd_host import smd_pkg::*; (
	input wire logic clk_sys,
	input wire logic ack,
	input wire logic reject,
	output smd_cmd_s cmd
);
	initial cmd = '0;
	// Send one command, then watch three cycles for the answer
	task automatic send(input logic [7:0] c, input logic [15:0] m, input logic [15:0] d, output logic ga,
		output logic gr);
		ga = 1'b0;
		gr = 1'b0;
		@(posedge clk_sys);
		#1 cmd = '{1'b1, c, m, d};
		@(posedge clk_sys);
		#1 cmd = '{1'b0, 8'h0, ~m, ~d};
		repeat (3) begin
			ga = ga | ack;
			gr = gr | reject;
			@(posedge clk_sys);
			#1;
		end
	endtask
endmodule // smd_host

// ===== verif/smd_decoder_bench.sv
// Self-checking bench for the set-mode decoder
`timescale 1ns/10ps
`include "smd_map.svh"
module smd_decoder_bench import smd_pkg::*; ();
	logic clk_sys, reset, motor_enabled, hw_drive_disable, motion_active, ack, reject, ga, gr;
	logic limit_switch_select, group_response_enable, dc_motor_select, hirate_enable;
	logic nonzero_endspeed_enable, ff_use_loop_filter, short_active, cycle_pulse, cs_keepalive;
	logic [1:0] analog_feedback_select;
	logic [2:0] spi_rate_a, spi_rate_b, hall_value;
	logic [4:0] gen_inputs;
	logic [15:0] velocity_crossover, pulse_width_read, encoder_multiplier, spi_delay_ticks, ff_coeff, i2c_addr;
	logic [31:0] sine_freq, sine_phase;
	logic sine_enable, hall_input_read, i2c_setup, i2c_tx, i2c_rx;
	logic [15:0] analog_input_filter, drive_voltage_filter, sine_base, i2c_reg;
	smd_cmd_s cmd;
	int num_errors = 0;
	int total_checks = 0;
	int n_setup = 0;
	int n_tx = 0;
	int n_rx = 0;
	smd_host host (.clk_sys, .ack, .reject, .cmd);
	smd_decoder uut (.clk_sys, .reset, .cmd, .motor_enabled, .hw_drive_disable, .motion_active,
		.sine_freq, .gen_inputs, .ack, .reject, .limit_switch_select, .group_response_enable,
		.dc_motor_select, .analog_feedback_select, .analog_input_filter, .drive_voltage_filter,
		.velocity_crossover, .pulse_width_read, .hirate_enable, .nonzero_endspeed_enable,
		.encoder_multiplier, .spi_rate_a, .spi_rate_b, .spi_delay_ticks, .ff_coeff, .ff_use_loop_filter,
		.sine_base, .sine_enable, .hall_input_read, .hall_value, .short_active, .i2c_addr,
		.i2c_setup, .i2c_tx, .i2c_rx, .i2c_reg, .cycle_pulse, .cs_keepalive, .sine_phase);
	// Count the one-cycle I2C strobes
	always @(posedge clk_sys) begin
		if (i2c_setup === 1'b1) n_setup <= n_setup + 1;
		if (i2c_tx === 1'b1) n_tx <= n_tx + 1;
		if (i2c_rx === 1'b1) n_rx <= n_rx + 1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One command with its answer checked
	task automatic run(input logic [15:0] m, input logic [15:0] d, input logic rj);
		host.send(`SMD_CMD_CODE, m, d, ga, gr);
		chk(32'(ga), 32'h1);
		chk(32'(gr), 32'(rj));
	endtask
	task automatic wait_pulse();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (!cycle_pulse && n < 13000);
		if (!cycle_pulse) num_errors++;
	endtask
	task automatic summarize();
		if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always #5 clk_sys = ~clk_sys;
	// Watchdog
	initial begin
		#600000;
		num_errors++;
		summarize();
	end
	initial begin
		clk_sys = 1'b0;
		reset = 1'b1;
		{motor_enabled, hw_drive_disable, motion_active} = 3'h0;
		sine_freq = 32'h5;
		gen_inputs = 5'h14;
		repeat (20) @(posedge clk_sys);
		#1 reset = 1'b0;
		chk(32'(encoder_multiplier), 32'h1);
		chk(32'(ff_use_loop_filter), 32'h1);
		run(16'h1, 16'h1, 1'b0);
		chk(32'(group_response_enable), 32'h1);
		run(16'h0, 16'h1, 1'b0);
		chk(32'(limit_switch_select), 32'h1);
		run(16'h0, 16'h0, 1'b0);
		chk(32'(limit_switch_select), 32'h0);
		run(16'h2, 16'h1, 1'b0);
		chk(32'(dc_motor_select), 32'h1);
		run(16'h3, 16'h3, 1'b0);
		run(16'h3, 16'h2, 1'b1);
		chk(32'(analog_feedback_select), 32'h3);
		run(16'h6, 16'h123, 1'b0);
		chk(32'(velocity_crossover), 32'h123);
		run(16'h4, 16'h11, 1'b0);
		chk(32'(analog_input_filter), 32'h11);
		run(16'h5, 16'h22, 1'b0);
		chk(32'(drive_voltage_filter), 32'h22);
		run(16'h7, 16'h4, 1'b0);
		chk(32'(pulse_width_read), 32'h4);
		run(16'h9, 16'h1, 1'b0);
		chk(32'(hirate_enable), 32'h1);
		run(16'hF, 16'h1, 1'b0);
		chk(32'(nonzero_endspeed_enable), 32'h1);
		run(16'h12, 16'h0, 1'b0);
		chk(32'(encoder_multiplier), 32'h1);
		run(16'h12, 16'h5, 1'b0);
		chk(32'(encoder_multiplier), 32'h5);
		for (int i = 0; i < 7; i++) begin
			run(16'h14, 16'(i), 1'b0);
			chk(32'(spi_rate_a), 32'(i));
			run(16'h15, 16'(i), 1'b0);
			chk(32'(spi_rate_b), 32'(i));
		end
		run(16'h14, 16'h7, 1'b1);
		run(16'h18, 16'h3E8, 1'b0);
		chk({16'h0, ff_coeff}, 32'h3E8);
		chk(32'(ff_use_loop_filter), 32'h0);
		host.send(8'h57, 16'h1, 16'h0, ga, gr);
		chk(32'(ga), 32'h0);
		chk(32'(group_response_enable), 32'h1);
		run(16'h1C, 16'h42, 1'b0);
		chk({16'h0, i2c_addr}, 32'h42);
		run(16'h1D, 16'h30, 1'b0);
		chk(32'(i2c_reg), 32'h30);
		run(16'h1E, 16'h31, 1'b0);
		chk(32'(i2c_reg), 32'h31);
		chk(32'(n_setup), 32'h1);
		chk(32'(n_tx), 32'h1);
		chk(32'(n_rx), 32'h1);
		run(16'h1A, 16'h1, 1'b0);
		chk(32'(hall_input_read), 32'h1);
		repeat (2) @(posedge clk_sys);
		#1 chk(32'(hall_value), 32'h5);
		motor_enabled = 1'b1;
		run(16'h1B, 16'h1, 1'b0);
		motor_enabled = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 chk(32'(short_active), 32'h1);
		hw_drive_disable = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 chk(32'(short_active), 32'h0);
		run(16'h16, 16'h5, 1'b0);
		motion_active = 1'b1;
		run(16'h19, 16'h1E, 1'b0);
		chk(32'(sine_base), 32'h1E);
		chk(32'(sine_enable), 32'h1);
		wait_pulse();
		chk(32'(cs_keepalive), 32'h1);
		wait_pulse();
		@(posedge clk_sys);
		#1 chk(sine_phase, 32'hA);
		motion_active = 1'b0;
		wait_pulse();
		@(posedge clk_sys);
		#1 chk(sine_phase, 32'hA);
		summarize();
	end
endmodule // smd_decoder_bench
